// ---- rtl/osl_ctrl.sv ----
// Host controller that programs the clock device and locks out the
// withdrawn fast oscillator.
// Assumes software on a plain strobe port and the device register port.
//
// Operation
// R1 - Never select fast oscillator for any clock
// R2 - Keep fast oscillator enable at zero
// R3 - Keep source select bit at zero
// R4 - Keep divide-by-128 select at zero
// R5 - Never program wake clock field to 10b
// R6 - Never write divider or trim registers
// R7 - Timer C count source not 110b/111b
// R8 - Timer D count sources not 110b/111b
// R9 - No fast capture trigger for timer C
// R10 - No fast capture trigger for timer D
// R11 - Reserved and unassigned bits written zero
// R12 - Change source only when enabled, slow on
// R13 - Oscillator control register resets to zero
// R14 - Hold fast clock off, flag forbidden attempts
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
module osl_ctrl (
	input  wire logic                     i_clk,
	input  wire logic                     i_rst_n,
	input  wire osl_pkg::osl_sw_req_type  i_sw,
	output logic [7:0]                    o_sw_rdata,
	output osl_pkg::osl_dev_req_type      o_dev,
	input  wire logic [7:0]               i_dev_rdata,
	output logic                          o_refused,
	output logic                          o_fast_clock_off
);

	// ************************************************************
	// State
	// ************************************************************
	typedef enum logic [1:0] {
		OSL_IDLE = 2'b00,
		OSL_READ = 2'b01,
		OSL_WAIT = 2'b10
	} osl_phase_type;

	typedef struct packed {
		osl_phase_type          phase;
		logic [3:0]             cmd_addr;
		logic [7:0]             cmd_data;
		logic                   busy;
		logic                   refused;
		osl_pkg::osl_reason_type reason;
		logic [7:0]             refusals;
		logic [7:0]             read_data;
		logic [7:0]             osc_shadow;
		logic [7:0]             slow_ctrl;
		logic [7:0]             sw_rdata;
		osl_pkg::osl_dev_req_type dev;
	} osl_state_type;

	osl_state_type st_q;
	osl_state_type st_d;
	logic [1:0]    rst_sync_q;
	logic          rst_n;
	osl_pkg::osl_reason_type chk_reason;
	logic          slow_on;

	// ************************************************************
	// Reset release
	// ************************************************************
	// Kept out of the state struct: only the raw reset may clear it
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// Slow oscillator runs when its stop bit is clear
	assign slow_on = !st_q.slow_ctrl[osl_pkg::SLOW_STOP_BIT];

	// Legality check of the pending command
	osl_guard u_guard (
		.i_addr       (st_q.cmd_addr),
		.i_data       (st_q.cmd_data),
		.i_osc_shadow (st_q.osc_shadow),
		.i_slow_on    (slow_on),
		.o_reason     (chk_reason)
	);

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		st_d          = st_q;
		st_d.dev      = '0;
		st_d.sw_rdata = 8'h00;
		// Software writes
		if (i_sw.wr) begin
			unique case (i_sw.addr)
				osl_pkg::CR_CMD_ADDR: st_d.cmd_addr = i_sw.wdata[3:0];
				osl_pkg::CR_CMD_DATA: st_d.cmd_data = i_sw.wdata;
				osl_pkg::CR_STATUS: begin
					st_d.refused = 1'b0;
				end
				default: ;
			endcase
		end
		// Software reads
		if (i_sw.rd) begin
			unique case (i_sw.addr)
				osl_pkg::CR_CMD_ADDR:   st_d.sw_rdata = {4'h0, st_q.cmd_addr};
				osl_pkg::CR_CMD_DATA:   st_d.sw_rdata = st_q.cmd_data;
				osl_pkg::CR_STATUS:
					st_d.sw_rdata = {3'h0, st_q.reason, st_q.refused,
					                 st_q.busy};
				osl_pkg::CR_READ_DATA:  st_d.sw_rdata = st_q.read_data;
				osl_pkg::CR_SHADOW_OSC: st_d.sw_rdata = st_q.osc_shadow;
				osl_pkg::CR_REFUSALS:   st_d.sw_rdata = st_q.refusals;
				default:                st_d.sw_rdata = 8'h00;
			endcase
		end
		// Sequencer
		unique case (st_q.phase)
			OSL_IDLE: begin
				if (i_sw.wr && i_sw.addr == osl_pkg::CR_CMD_GO) begin
					if (i_sw.wdata[osl_pkg::GO_READ_BIT]) begin
						st_d.dev.rd   = 1'b1;
						st_d.dev.addr = st_q.cmd_addr;
						st_d.busy     = 1'b1;
						st_d.phase    = OSL_READ;
					end else if (i_sw.wdata[osl_pkg::GO_WRITE_BIT]) begin
						st_d.busy  = 1'b1;
						st_d.phase = OSL_WAIT;
					end
				end
			end
			OSL_READ: begin
				st_d.read_data = i_dev_rdata;
				st_d.busy      = 1'b0;
				st_d.phase     = OSL_IDLE;
			end
			OSL_WAIT: begin
				// Forbidden values never reach the device
				if (chk_reason != osl_pkg::OSL_OK) begin
					st_d.refused  = 1'b1; // R14
					st_d.reason   = chk_reason;
					st_d.refusals = st_q.refusals + 8'h01;
				end else begin
					st_d.dev.wr    = 1'b1; // R1
					st_d.dev.addr  = st_q.cmd_addr;
					st_d.dev.wdata = st_q.cmd_data;
					st_d.reason    = osl_pkg::OSL_OK;
					if (st_q.cmd_addr == osl_pkg::DEV_OSC_CTRL_0) begin
						st_d.osc_shadow = st_q.cmd_data;
					end
					if (st_q.cmd_addr == osl_pkg::DEV_SYS_CLK_1) begin
						st_d.slow_ctrl = st_q.cmd_data;
					end
				end
				st_d.busy  = 1'b0;
				st_d.phase = OSL_IDLE;
			end
			default: begin
				st_d.phase = OSL_IDLE;
			end
		endcase
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q.phase      <= OSL_IDLE;
			st_q.cmd_addr   <= 4'h0;
			st_q.cmd_data   <= 8'h00;
			st_q.busy       <= 1'b0;
			st_q.refused    <= 1'b0;
			st_q.reason     <= osl_pkg::OSL_OK;
			st_q.refusals   <= 8'h00;
			st_q.read_data  <= 8'h00;
			st_q.osc_shadow <= osl_pkg::OSC_CTRL_0_RESET; // R13
			st_q.slow_ctrl  <= 8'h00;
			st_q.sw_rdata   <= 8'h00;
			st_q.dev        <= '0;
		end else begin
			st_q.phase      <= st_d.phase;
			st_q.cmd_addr   <= st_d.cmd_addr;
			st_q.cmd_data   <= st_d.cmd_data;
			st_q.busy       <= st_d.busy;
			st_q.refused    <= st_d.refused | (st_q.phase == OSL_WAIT &&
			                   chk_reason != osl_pkg::OSL_OK);
			st_q.reason     <= st_d.reason;
			st_q.refusals   <= st_d.refusals;
			st_q.read_data  <= st_d.read_data;
			st_q.osc_shadow <= st_d.osc_shadow;
			st_q.slow_ctrl  <= st_d.slow_ctrl;
			st_q.sw_rdata   <= st_d.sw_rdata;
			st_q.dev        <= st_d.dev;
		end
	end

	// Outputs
	assign o_dev            = st_q.dev;
	assign o_sw_rdata       = st_q.sw_rdata;
	assign o_refused        = st_q.refused;
	assign o_fast_clock_off = !st_q.osc_shadow[osl_pkg::OSC_ENABLE_BIT]; // R14

	// ************************************************************
	// Checks
	// ************************************************************
	sequence s_go_write;
		st_q.phase == OSL_IDLE && i_sw.wr && i_sw.addr == osl_pkg::CR_CMD_GO
		&& !i_sw.wdata[osl_pkg::GO_READ_BIT]
		&& i_sw.wdata[osl_pkg::GO_WRITE_BIT];
	endsequence

	sequence s_bad_check;
		st_q.phase == OSL_WAIT && chk_reason != osl_pkg::OSL_OK;
	endsequence

	// Software clears the refusal flag through the status register
	sequence s_status_clear;
		i_sw.wr && i_sw.addr == osl_pkg::CR_STATUS;
	endsequence

	// Read command taken while the sequencer is idle
	sequence s_read_go;
		st_q.phase == OSL_IDLE && i_sw.wr && i_sw.addr == osl_pkg::CR_CMD_GO
		&& i_sw.wdata[osl_pkg::GO_READ_BIT];
	endsequence

	// Device writes never carry a forbidden oscillator setting
	a_osc_enable_low: assert property ( // R2
		@(posedge i_clk) disable iff (!rst_n)
		o_dev.wr && o_dev.addr == osl_pkg::DEV_OSC_CTRL_0 |->
		!o_dev.wdata[osl_pkg::OSC_ENABLE_BIT])
		else $error("fast oscillator enable written");
	a_osc_source_low: assert property ( // R3
		@(posedge i_clk) disable iff (!rst_n)
		o_dev.wr && o_dev.addr == osl_pkg::DEV_OSC_CTRL_0 |->
		!o_dev.wdata[osl_pkg::OSC_SOURCE_BIT])
		else $error("source select written high");
	a_div_select_low: assert property ( // R4
		@(posedge i_clk) disable iff (!rst_n)
		o_dev.wr && o_dev.addr == osl_pkg::DEV_OSC_CTRL_0 |->
		o_dev.wdata[osl_pkg::OSC_DIV128_BIT] == 1'b0)
		else $error("divide select written high");
	a_osc_spare_zero: assert property ( // R11
		@(posedge i_clk) disable iff (!rst_n)
		o_dev.wr && o_dev.addr == osl_pkg::DEV_OSC_CTRL_0 |->
		(o_dev.wdata & ~osl_pkg::OSC_CTRL_0_MASK) == 8'h00)
		else $error("reserved bits written nonzero");
	a_wake_not_fast: assert property ( // R5
		@(posedge i_clk) disable iff (!rst_n)
		o_dev.wr && o_dev.addr == osl_pkg::DEV_SYS_CLK_3 |->
		o_dev.wdata[7:6] != osl_pkg::WAKE_FAST)
		else $error("wake clock set to fast");
	a_no_trim_write: assert property ( // R6
		@(posedge i_clk) disable iff (!rst_n)
		o_dev.wr |-> !(o_dev.addr >= osl_pkg::DEV_FAST_DIV &&
		o_dev.addr <= osl_pkg::DEV_TRIM_7))
		else $error("divider or trim register written");
	a_cnt_c_legal: assert property ( // R7
		@(posedge i_clk) disable iff (!rst_n)
		o_dev.wr && o_dev.addr == osl_pkg::DEV_TIMER_C_CTL1 |->
		o_dev.wdata[2:1] != 2'h3)
		else $error("timer C count source fast");
	a_cnt_d_legal: assert property ( // R8
		@(posedge i_clk) disable iff (!rst_n)
		o_dev.wr && (o_dev.addr == osl_pkg::DEV_TIMER_D_CTL0 ||
		o_dev.addr == osl_pkg::DEV_TIMER_D_CTL1) |->
		o_dev.wdata[2:1] != 2'h3)
		else $error("timer D count source fast");
	a_capture_legal: assert property ( // R9 R10
		@(posedge i_clk) disable iff (!rst_n)
		o_dev.wr && o_dev.addr == osl_pkg::DEV_CAPTURE_SEL |->
		!o_dev.wdata[osl_pkg::CAP_FAST_BIT])
		else $error("fast capture trigger selected");

	// Refusals are flagged, counted, held and cleared only by software
	a_refuse_flags: assert property ( // R14
		@(posedge i_clk) disable iff (!rst_n)
		s_bad_check |=> o_refused && !o_dev.wr &&
		st_q.refusals == $past(st_q.refusals) + 8'h01)
		else $error("forbidden write not flagged");
	a_refuse_clear: assert property ( // R14
		@(posedge i_clk) disable iff (!rst_n)
		s_status_clear ##0 (st_q.phase != OSL_WAIT ||
		chk_reason == osl_pkg::OSL_OK) |=> !o_refused)
		else $error("refusal flag not cleared");
	a_refuse_sticky: assert property ( // R14
		@(posedge i_clk) disable iff (!rst_n)
		o_refused && !(i_sw.wr && i_sw.addr == osl_pkg::CR_STATUS) |=>
		o_refused)
		else $error("refusal flag dropped");

	// Command sequencing: writes issue once checked, reads never write
	a_write_timing: assert property ( // R12
		@(posedge i_clk) disable iff (!rst_n)
		s_go_write ##1 (chk_reason == osl_pkg::OSL_OK) |=> o_dev.wr)
		else $error("legal write not issued");
	a_busy_done: assert property ( // R14
		@(posedge i_clk) disable iff (!rst_n)
		s_go_write |=> st_q.busy ##1 !st_q.busy)
		else $error("busy flag wrong around a write");
	a_read_no_write: assert property ( // R6
		@(posedge i_clk) disable iff (!rst_n)
		s_read_go |=> o_dev.rd && !o_dev.wr)
		else $error("read command issued a write");
	a_read_capture: assert property ( // R11
		@(posedge i_clk) disable iff (!rst_n)
		o_dev.rd |=> st_q.read_data == $past(i_dev_rdata))
		else $error("device read data not captured");

	// The fast oscillator stays off and its register at reset value
	a_clock_held_off: assert property ( // R1 R13
		@(posedge i_clk) disable iff (!rst_n)
		o_fast_clock_off)
		else $error("fast clock not held off");
	a_shadow_reset: assert property ( // R13
		@(posedge i_clk) disable iff (!rst_n)
		st_q.osc_shadow == osl_pkg::OSC_CTRL_0_RESET)
		else $error("oscillator shadow left reset value");

endmodule

// ---- rtl/osl_pkg.sv ----
// Package for the oscillator source lockout controller
// Assumes a single 20 MHz system clock and an active-low reset
package osl_pkg;

	// ************************************************************
	// Device register map (reached through the device port)
	// ************************************************************
	localparam logic [3:0] DEV_OSC_CTRL_0   = 4'h0;
	localparam logic [3:0] DEV_SYS_CLK_3    = 4'h1;
	localparam logic [3:0] DEV_SYS_CLK_1    = 4'h2;
	localparam logic [3:0] DEV_FAST_DIV     = 4'h3;
	localparam logic [3:0] DEV_TRIM_1       = 4'h4;
	localparam logic [3:0] DEV_TRIM_3       = 4'h5;
	localparam logic [3:0] DEV_TRIM_4       = 4'h6;
	localparam logic [3:0] DEV_TRIM_5       = 4'h7;
	localparam logic [3:0] DEV_TRIM_6       = 4'h8;
	localparam logic [3:0] DEV_TRIM_7       = 4'h9;
	localparam logic [3:0] DEV_TIMER_C_CTL1 = 4'ha;
	localparam logic [3:0] DEV_TIMER_D_CTL0 = 4'hb;
	localparam logic [3:0] DEV_TIMER_D_CTL1 = 4'hc;
	localparam logic [3:0] DEV_CAPTURE_SEL  = 4'hd;

	// ************************************************************
	// Field positions and values
	// ************************************************************
	localparam int          OSC_ENABLE_BIT   = 0;
	localparam int          OSC_SOURCE_BIT   = 1;
	localparam int          OSC_RESERVED_BIT = 2;
	localparam int          OSC_DIV128_BIT   = 3;
	localparam logic [7:0]  OSC_CTRL_0_RESET = 8'h00;
	localparam logic [7:0]  OSC_CTRL_0_MASK  = 8'h0b;
	localparam int          WAKE_SEL_LO      = 6;
	localparam logic [1:0]  WAKE_FAST        = 2'h2;
	localparam int          SLOW_STOP_BIT    = 4;
	localparam int          CNT_SRC_LO       = 0;
	localparam logic [2:0]  CNT_SRC_40M      = 3'h6;
	localparam logic [2:0]  CNT_SRC_FAST     = 3'h7;
	localparam int          CAP_FAST_BIT     = 0;

	// ************************************************************
	// Controller register map (software side)
	// ************************************************************
	localparam logic [3:0] CR_CMD_ADDR   = 4'h0;
	localparam logic [3:0] CR_CMD_DATA   = 4'h1;
	localparam logic [3:0] CR_CMD_GO     = 4'h2;
	localparam logic [3:0] CR_STATUS     = 4'h3;
	localparam logic [3:0] CR_READ_DATA  = 4'h4;
	localparam logic [3:0] CR_SHADOW_OSC = 4'h5;
	localparam logic [3:0] CR_REFUSALS   = 4'h6;
	localparam int         GO_WRITE_BIT  = 0;
	localparam int         GO_READ_BIT   = 1;

	// Refusal reason codes
	typedef enum logic [2:0] {
		OSL_OK        = 3'h0,
		OSL_BAD_OSC   = 3'h1,
		OSL_BAD_WAKE  = 3'h2,
		OSL_BAD_TRIM  = 3'h3,
		OSL_BAD_CNT   = 3'h4,
		OSL_BAD_CAPT  = 3'h5,
		OSL_BAD_ORDER = 3'h6
	} osl_reason_type;

	// Device port carrier
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} osl_dev_req_type;

	// Software port carrier
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} osl_sw_req_type;

endpackage

// ---- rtl/osl_guard.sv ----
// Legality check of one device register write
// Assumes inputs from logic on the same clock; output is combinational
`timescale 1ns/100ps
module osl_guard (
	input  wire logic [3:0]          i_addr,
	input  wire logic [7:0]          i_data,
	input  wire logic [7:0]          i_osc_shadow,
	input  wire logic                i_slow_on,
	output osl_pkg::osl_reason_type  o_reason
);

	logic [2:0] cnt_src;
	logic [1:0] wake;

	assign cnt_src = i_data[osl_pkg::CNT_SRC_LO +: 3];
	assign wake    = i_data[osl_pkg::WAKE_SEL_LO +: 2];

	// Classify the write by target register
	always_comb begin
		o_reason = osl_pkg::OSL_OK;
		unique case (i_addr)
			osl_pkg::DEV_OSC_CTRL_0: begin
				if ((i_data & ~osl_pkg::OSC_CTRL_0_MASK) != 8'h00 ||
				    i_data[osl_pkg::OSC_ENABLE_BIT] ||
				    i_data[osl_pkg::OSC_DIV128_BIT] ||
				    i_data[osl_pkg::OSC_SOURCE_BIT]) begin
					o_reason = osl_pkg::OSL_BAD_OSC; // R2 R3 R4 R11
				end else if (i_data[osl_pkg::OSC_SOURCE_BIT] !=
				    i_osc_shadow[osl_pkg::OSC_SOURCE_BIT] &&
				    !(i_osc_shadow[osl_pkg::OSC_ENABLE_BIT] &&
				    i_slow_on)) begin
					o_reason = osl_pkg::OSL_BAD_ORDER; // R12
				end
			end
			osl_pkg::DEV_SYS_CLK_3: begin
				if (wake == osl_pkg::WAKE_FAST) begin
					o_reason = osl_pkg::OSL_BAD_WAKE; // R5
				end
			end
			osl_pkg::DEV_FAST_DIV, osl_pkg::DEV_TRIM_1,
			osl_pkg::DEV_TRIM_3, osl_pkg::DEV_TRIM_4, osl_pkg::DEV_TRIM_5,
			osl_pkg::DEV_TRIM_6, osl_pkg::DEV_TRIM_7: begin
				o_reason = osl_pkg::OSL_BAD_TRIM; // R6
			end
			osl_pkg::DEV_TIMER_C_CTL1, osl_pkg::DEV_TIMER_D_CTL0,
			osl_pkg::DEV_TIMER_D_CTL1: begin
				if (cnt_src == osl_pkg::CNT_SRC_40M ||
				    cnt_src == osl_pkg::CNT_SRC_FAST) begin
					o_reason = osl_pkg::OSL_BAD_CNT; // R7 R8
				end
			end
			osl_pkg::DEV_CAPTURE_SEL: begin
				if (i_data[osl_pkg::CAP_FAST_BIT]) begin
					o_reason = osl_pkg::OSL_BAD_CAPT; // R9 R10
				end
			end
			default: begin
				o_reason = osl_pkg::OSL_OK;
			end
		endcase
	end

endmodule

// ---- verif/osl_dev_model.sv ----
// Behavioural model of the clock device register file
// Assumes the controller drives the device port on the shared clock
`timescale 1ns/100ps
module osl_dev_model (
	input  wire logic                     i_clk,
	input  wire logic                     i_rst_n,
	input  wire osl_pkg::osl_dev_req_type i_dev,
	output logic [7:0]                    o_rdata
);
	logic [7:0] mem_q [16];
	int         wr_count;
	int         bad_seen;
	logic       bad;
	logic [7:0] rmask;
	logic [7:0] idle_q;

	// ************************************************************
	// Forbidden settings seen at the device
	// ************************************************************
	// Flag any write the controller must never issue
	always_comb begin
		bad = 1'b0;
		case (i_dev.addr)
			osl_pkg::DEV_OSC_CTRL_0: bad = (i_dev.wdata != 8'h00);
			osl_pkg::DEV_SYS_CLK_3: bad = (i_dev.wdata[7:6] == 2'h2);
			osl_pkg::DEV_TIMER_C_CTL1, osl_pkg::DEV_TIMER_D_CTL0,
			osl_pkg::DEV_TIMER_D_CTL1: bad = (i_dev.wdata[2:1] == 2'h3);
			osl_pkg::DEV_CAPTURE_SEL: bad = i_dev.wdata[0];
			default: bad = (i_dev.addr >= 4'h3) && (i_dev.addr <= 4'h9);
		endcase
	end

	// Unassigned bits of the oscillator control register read as zero
	assign rmask = (i_dev.addr == osl_pkg::DEV_OSC_CTRL_0) ? 8'h0f : 8'hff;

	// ************************************************************
	// Register file and read port
	// ************************************************************
	// Read data stand while the read strobe is high: the controller takes
	// them at the edge that ends that cycle. Between reads the bus toggles
	// so stale values never look valid
	assign o_rdata = i_dev.rd ? (mem_q[i_dev.addr] & rmask) : idle_q;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int i = 0; i < 16; i++)
				mem_q[i] <= 8'h00;
			idle_q   <= 8'h00;
			wr_count <= 0;
			bad_seen <= 0;
		end else begin
			if (i_dev.wr) begin
				mem_q[i_dev.addr] <= i_dev.wdata;
				wr_count          <= wr_count + 1;
				bad_seen          <= bad_seen + int'(bad);
			end
			idle_q <= ~idle_q;
		end
	end
endmodule

// ---- verif/oscillator_source_lockout_bench.sv ----
// Self-checking bench of the oscillator source lockout controller
// Assumes the controller package and the device model are compiled first
`timescale 1ns/100ps
`define CHK(a, b) begin \
	checks++; \
	if ((a) !== (b)) begin \
		bad_count++; \
		$display("Error %0t: got %h want %h", $time, a, b); \
	end \
end
module oscillator_source_lockout_bench;
	logic                     i_clk   = 1'b0;
	logic                     i_rst_n = 1'b0;
	osl_pkg::osl_sw_req_type  sw      = '0;
	osl_pkg::osl_dev_req_type dev;
	logic [7:0]               sw_rdata;
	logic [7:0]               dev_rdata;
	logic                     refused;
	logic                     fast_off;
	logic [7:0]               exp_q [$];
	logic [7:0]               exp_v;
	logic                     rd_pend = 1'b0;
	logic [7:0]               bad_osc [6] = '{8'h01, 8'h02, 8'h08,
	                                          8'h04, 8'h10, 8'h80};
	int                       bad_count = 0;
	int                       checks    = 0;
	int                       cycles    = 0;
	int                       seed      = 86;
	int                       nref      = 0;
	int                       nleg      = 0;

	osl_ctrl osl_ctrl_i (
		.i_clk            (i_clk),
		.i_rst_n          (i_rst_n),
		.i_sw             (sw),
		.o_sw_rdata       (sw_rdata),
		.o_dev            (dev),
		.i_dev_rdata      (dev_rdata),
		.o_refused        (refused),
		.o_fast_clock_off (fast_off)
	);

	osl_dev_model osl_dev_model_i (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_dev   (dev),
		.o_rdata (dev_rdata)
	);

	// 20 MHz clock
	always #25 i_clk = ~i_clk;

	// ************************************************************
	// Shared tasks
	// ************************************************************
	function automatic logic [7:0] rnd();
		return 8'($random(seed));
	endfunction

	task automatic print_verdict();
		if (bad_count == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// One software port cycle, changed just after the edge
	task automatic op(input logic w, input logic r, input logic [3:0] a,
		input logic [7:0] d);
		@(posedge i_clk);
		sw <= '{wr: w, rd: r, addr: a, wdata: d};
	endtask

	// Read with its expected value noted for the monitor
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		op(1'b0, 1'b1, a, rnd());
	endtask

	// Device command through the controller registers
	task automatic cmd(input logic [3:0] a, input logic [7:0] d,
		input logic [1:0] go);
		op(1'b1, 1'b0, osl_pkg::CR_CMD_ADDR, {4'h0, a});
		op(1'b1, 1'b0, osl_pkg::CR_CMD_DATA, d);
		op(1'b1, 1'b0, osl_pkg::CR_CMD_GO, {6'h00, go});
		op(1'b0, 1'b0, 4'h0, 8'h00);
		repeat (3) @(posedge i_clk);
	endtask

	// Forbidden write: refused, reason and count reported, flag cleared
	task automatic refuse(input logic [3:0] a, input logic [7:0] d,
		input osl_pkg::osl_reason_type why);
		cmd(a, d, 2'h1);
		nref++;
		`CHK(refused, 1'b1)
		rd(osl_pkg::CR_STATUS, {3'h0, why, 2'h2});
		rd(osl_pkg::CR_REFUSALS, 8'(nref));
		op(1'b1, 1'b0, osl_pkg::CR_STATUS, 8'h00);
		op(1'b0, 1'b0, 4'h0, 8'h00);
		@(posedge i_clk);
		`CHK(refused, 1'b0)
	endtask

	// Legal write, then read back from the device
	task automatic legal(input logic [3:0] a, input logic [7:0] d);
		cmd(a, d, 2'h1);
		nleg++;
		`CHK(refused, 1'b0)
		cmd(a, 8'h00, 2'h2);
		rd(osl_pkg::CR_READ_DATA, d);
	endtask

	// ************************************************************
	// Monitor: read data stands in the cycle after the read strobe
	// ************************************************************
	always @(posedge i_clk) begin
		cycles++;
		if (rd_pend) begin
			exp_v = exp_q.pop_front();
			`CHK(sw_rdata, exp_v)
		end
		rd_pend <= sw.rd;
		if (cycles == 6000) begin
			bad_count++;
			print_verdict();
		end
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		logic [7:0] d;
		repeat (12) @(posedge i_clk);
		i_rst_n <= 1'b1;
		repeat (3) @(posedge i_clk);
		`CHK(fast_off, 1'b1)
		rd(osl_pkg::CR_SHADOW_OSC, 8'h00);
		rd(4'hf, 8'h00);
		op(1'b1, 1'b0, 4'he, rnd());
		legal(osl_pkg::DEV_OSC_CTRL_0, 8'h00);
		foreach (bad_osc[i])
			refuse(osl_pkg::DEV_OSC_CTRL_0, bad_osc[i], osl_pkg::OSL_BAD_OSC);
		d = rnd();
		refuse(osl_pkg::DEV_SYS_CLK_3, {2'h2, d[5:0]}, osl_pkg::OSL_BAD_WAKE);
		for (int a = 3; a <= 9; a++)
			refuse(4'(a), rnd(), osl_pkg::OSL_BAD_TRIM);
		for (int a = 10; a <= 12; a++)
			for (int s = 6; s <= 7; s++) begin
				d = rnd();
				refuse(4'(a), {d[7:3], 3'(s)}, osl_pkg::OSL_BAD_CNT);
			end
		d = rnd();
		refuse(osl_pkg::DEV_CAPTURE_SEL, {d[7:1], 1'b1}, osl_pkg::OSL_BAD_CAPT);
		for (int s = 0; s <= 5; s++) begin
			d = rnd();
			legal(osl_pkg::DEV_TIMER_D_CTL1, {d[7:3], 3'(s)});
		end
		legal(osl_pkg::DEV_TIMER_C_CTL1, 8'h05);
		legal(osl_pkg::DEV_SYS_CLK_3, 8'h40);
		legal(osl_pkg::DEV_SYS_CLK_3, 8'hc0);
		legal(osl_pkg::DEV_CAPTURE_SEL, 8'h00);
		rd(osl_pkg::CR_SHADOW_OSC, 8'h00);
		op(1'b0, 1'b0, 4'h0, 8'h00);
		repeat (4) @(posedge i_clk);
		`CHK(fast_off, 1'b1)
		`CHK(osl_dev_model_i.bad_seen, 0)
		`CHK(osl_dev_model_i.wr_count, nleg)
		print_verdict();
	end
endmodule
